// File: design/mdc_defines.svh
// constants of the multi-channel transfer engine: offsets, fields, codes
// assumes it is included once per file by its bare name
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH
`define MDC_NCH 5
`define MDC_AW 6
`define MDC_OFS_ARM 6'h00
`define MDC_OFS_REQ 6'h04
`define MDC_OFS_DONE 6'h08
`define MDC_OFS_CFG0 6'h10
`define MDC_CFG_STRIDE 6'h04
`define MDC_ABORT_BIT 7
`define MDC_DESC_LAST 3'h7
// descriptor held big-endian: byte 0 in bits 63:56
`define MDC_D_SRC 63:48
`define MDC_D_DST 47:32
`define MDC_D_LENGTH_FROM_DATA_MODE 31:29
`define MDC_D_LEN 28:16
`define MDC_D_WSZ 15
`define MDC_D_TRANSFER_MODE_FIELD 14:13
`define MDC_D_TRIGGER_SELECT 12:8
`define MDC_D_SINC 7:6
`define MDC_D_DINC 5:4
`define MDC_D_IE 3
`define MDC_D_M8 2
`define MDC_D_PRIO 1:0
`define MDC_TRIGGER_SELECT_NONE 5'h00
`define MDC_TRIGGER_SELECT_PREV 5'h01
`define MDC_TRIGGER_SELECT_PORT0 5'h0C
`define MDC_TRIGGER_SELECT_PORT1 5'h0D
`define MDC_LENGTH_FROM_DATA_MODE_FIX0 3'h0
`define MDC_LENGTH_FROM_DATA_MODE_P1 3'h1
`define MDC_LENGTH_FROM_DATA_MODE_P0 3'h2
`define MDC_LENGTH_FROM_DATA_MODE_P2 3'h3
`define MDC_LENGTH_FROM_DATA_MODE_P3 3'h4
`define MDC_LENGTH_FROM_DATA_MODE_FIX1 3'h7
`define MDC_TM_SINGLE 2'h0
`define MDC_TM_BLOCK 2'h1
`define MDC_TM_RSINGLE 2'h2
`define MDC_TM_RBLOCK 2'h3
`define MDC_INC_NONE 2'h0
`define MDC_INC_ONE 2'h1
`define MDC_INC_TWO 2'h2
`define MDC_INC_DEC 2'h3
`define MDC_PRIO_LOW 2'h0
`define MDC_PRIO_ASSURED 2'h1
`define MDC_PRIO_HIGH 2'h2
`endif

// File: design/mdc_dma.sv
// multi-channel memory-to-memory transfer engine with descriptor fetch
// assumes a byte-wide memory port answered by mem_ack, one clock, Avalon slave
`include "mdc_defines.svh"

module mdc_dma (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [15:0]      mem_addr,
  output logic             mem_read,
  output logic             mem_write,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        cpu_mem_req,
  input  wire logic [31:0] periph_trigger_select,
  input  wire logic [7:0]  port0_pins,
  input  wire logic [7:0]  port0_irq_en,
  input  wire logic [7:0]  port1_pins,
  input  wire logic [7:0]  port1_irq_en,
  output logic             done_irq
);
  import mdc_pkg::*;
  localparam int NCH = `MDC_NCH;

  mdc_state_t     s_ff;
  mdc_state_t     nxt_s;
  logic           acc;
  logic           wr_en;
  logic [NCH-1:0] ab;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // pointer step
  function automatic logic [15:0] step(input logic [15:0] p,
                                       input logic [1:0]  inc,
                                       input logic        w);
    logic [15:0] u;
    u = w ? 16'h0002 : 16'h0001;
    unique case (inc)
      `MDC_INC_NONE: return p;
      `MDC_INC_ONE:  return p + u;
      `MDC_INC_TWO:  return p + {u[14:0], 1'b0};
      `MDC_INC_DEC:  return p - u;
    endcase
  endfunction

  // total units from the length unit
  function automatic logic [12:0] vtotal(input logic [63:0] d,
                                         input logic [15:0] w);
    logic [13:0] v;
    logic [13:0] t;
    logic [13:0] mx;
    mx = {1'b0, d[`MDC_D_LEN]};
    if (d[`MDC_D_WSZ])
      v = {1'b0, w[12:0]};
    else if (d[`MDC_D_M8])
      v = {7'h00, w[6:0]};
    else
      v = {6'h00, w[7:0]};
    unique case (d[`MDC_D_LENGTH_FROM_DATA_MODE])
      `MDC_LENGTH_FROM_DATA_MODE_P1: t = v + 14'h0001;
      `MDC_LENGTH_FROM_DATA_MODE_P0: t = v;
      `MDC_LENGTH_FROM_DATA_MODE_P2: t = v + 14'h0002;
      `MDC_LENGTH_FROM_DATA_MODE_P3: t = v + 14'h0003;
      default:      t = mx;
    endcase
    if (t > mx)
      t = mx;
    return t[12:0];
  endfunction

  assign acc   = (avs_read | avs_write) & ~s_ff.waitreq;
  assign wr_en = acc & avs_write;
  assign ab = (wr_en && avs_address == `MDC_OFS_ARM &&
               avs_writedata[`MDC_ABORT_BIT]) ? avs_writedata[NCH-1:0] : '0;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    mdc_state_t     n;
    logic [4:0]     sel;
    logic           hit;
    logic [NCH-1:0] prv;
    logic [NCH-1:0] run;
    logic [31:0]    pe;
    logic [15:0]    pt;
    logic [63:0]    d;
    logic [2:0]     pk;
    logic           fnd;
    logic           go;
    logic [1:0]     pr;
    logic [15:0]    wd;
    logic [12:0]    c1;
    logic [12:0]    t1;
    logic           ld;
    logic [63:0]    ldd;
    n   = s_ff;
    sel = '0;
    hit = 1'b0;
    prv = {s_ff.prevp[NCH-2:0], 1'b0};
    run = '0;
    pe  = s_ff.ps2 & ~s_ff.ps3;
    pt  = (s_ff.pp2 ^ s_ff.pp3) & {port1_irq_en, port0_irq_en};
    d   = s_ff.desc[s_ff.ch];
    pk  = '0;
    fnd = 1'b0;
    go  = 1'b0;
    pr  = '0;
    wd  = s_ff.data;
    c1  = '0;
    t1  = '0;
    ld  = 1'b0;
    ldd = '0;
    n.irq   = 1'b0;
    n.prevp = '0;
    n.ps1   = periph_trigger_select;
    n.ps2   = s_ff.ps1;
    n.ps3   = s_ff.ps2;
    n.pp1   = {port1_pins, port0_pins};
    n.pp2   = s_ff.pp1;
    n.pp3   = s_ff.pp2;

    // ---------------------------------------------------------
    // register slave: one wait cycle, then the access
    // ---------------------------------------------------------
    n.waitreq = 1'b1;
    if ((avs_read | avs_write) && s_ff.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata   = '0;
      if (avs_address == `MDC_OFS_ARM)
        n.rdata = 32'(s_ff.armed);
      if (avs_address == `MDC_OFS_DONE)
        n.rdata = 32'(s_ff.done);
      for (int c = 0; c < NCH; c++) begin
        if (avs_address == `MDC_OFS_CFG0 + 6'(c) * `MDC_CFG_STRIDE)
          n.rdata = 32'(s_ff.cfg[c]);
      end
    end
    if (wr_en) begin
      if (avs_address == `MDC_OFS_ARM) begin
        if (avs_writedata[`MDC_ABORT_BIT]) begin
          n.armed = n.armed & ~ab;
          n.fetch = n.fetch & ~ab;
          n.pend  = n.pend & ~ab;
        end else begin
          n.fetch = n.fetch | (avs_writedata[NCH-1:0] & ~s_ff.armed);
        end
      end
      if (avs_address == `MDC_OFS_REQ)
        n.pend = n.pend | (avs_writedata[NCH-1:0] & s_ff.armed);
      // clear by writing zero; engine sets below win
      if (avs_address == `MDC_OFS_DONE)
        n.done = n.done & avs_writedata[NCH-1:0];
      for (int c = 0; c < NCH; c++) begin
        if (avs_address == `MDC_OFS_CFG0 + 6'(c) * `MDC_CFG_STRIDE)
          n.cfg[c] = avs_writedata[15:0];
      end
    end

    // ---------------------------------------------------------
    // trigger sensing
    // ---------------------------------------------------------
    for (int c = 0; c < NCH; c++) begin
      sel = s_ff.desc[c][`MDC_D_TRIGGER_SELECT];
      if (sel == `MDC_TRIGGER_SELECT_PREV)
        hit = prv[c];
      else if (sel == `MDC_TRIGGER_SELECT_PORT0)
        hit = |pt[7:0];
      else if (sel == `MDC_TRIGGER_SELECT_PORT1)
        hit = |pt[15:8];
      else if (sel != `MDC_TRIGGER_SELECT_NONE)
        hit = pe[sel];
      else
        hit = 1'b0;
      if (s_ff.armed[c] && !ab[c] && hit)
        n.pend[c] = 1'b1;
    end

    // ---------------------------------------------------------
    // engine
    // ---------------------------------------------------------
    unique case (s_ff.st)
      ST_IDLE: begin
        run = n.pend & n.armed & ~n.fetch;
        if (|n.fetch) begin
          for (int c = NCH - 1; c >= 0; c--) begin
            if (n.fetch[c])
              pk = 3'(c);
          end
          n.ch    = pk;
          n.bidx  = '0;
          n.st    = ST_FETCH;
          n.mrd   = 1'b1;
          n.maddr = s_ff.cfg[pk];
        end else if (|run) begin
          // high priority first, then lowest channel
          for (int c = NCH - 1; c >= 0; c--) begin
            if (run[c] && s_ff.desc[c][`MDC_D_PRIO] == `MDC_PRIO_HIGH) begin
              pk  = 3'(c);
              fnd = 1'b1;
            end
          end
          for (int c = NCH - 1; c >= 0; c--) begin
            if (run[c] && !fnd)
              pk = 3'(c);
          end
          pr = s_ff.desc[pk][`MDC_D_PRIO];
          go = (pr == `MDC_PRIO_HIGH) || !cpu_mem_req ||
               (pr == `MDC_PRIO_ASSURED && s_ff.defer);
          if (pr == `MDC_PRIO_ASSURED)
            n.defer = !go;
          if (go) begin
            n.ch       = pk;
            n.pend[pk] = 1'b0;
            n.hi       = 1'b0;
            n.st       = ST_RD;
            n.mrd      = 1'b1;
            n.maddr    = s_ff.src[pk];
          end
        end
      end
      ST_FETCH: begin
        if (ab[s_ff.ch]) begin
          n.st  = ST_IDLE;
          n.mrd = 1'b0;
        end else if (mem_ack) begin
          // byte k lands in the k-th byte from the top
          n.desc[s_ff.ch][(3'h7 - s_ff.bidx) * 8 +: 8] = mem_rdata;
          n.bidx  = s_ff.bidx + 3'h1;
          n.maddr = s_ff.maddr + 16'h0001;
          if (s_ff.bidx == `MDC_DESC_LAST) begin
            n.mrd            = 1'b0;
            n.st             = ST_IDLE;
            n.fetch[s_ff.ch] = 1'b0;
            n.armed[s_ff.ch] = 1'b1;
            ld  = 1'b1;
            ldd = {s_ff.desc[s_ff.ch][63:8], mem_rdata};
          end
        end
      end
      ST_RD: begin
        if (ab[s_ff.ch]) begin
          n.st  = ST_IDLE;
          n.mrd = 1'b0;
        end else if (mem_ack) begin
          // words are little-endian in memory
          if (s_ff.hi)
            wd[15:8] = mem_rdata;
          else
            wd[7:0] = mem_rdata;
          n.data = wd;
          if (d[`MDC_D_WSZ] && !s_ff.hi) begin
            n.hi    = 1'b1;
            n.maddr = s_ff.maddr + 16'h0001;
          end else begin
            n.hi    = 1'b0;
            n.mrd   = 1'b0;
            n.mwr   = 1'b1;
            n.mwd   = wd[7:0];
            n.maddr = s_ff.dst[s_ff.ch];
            n.st    = ST_WR;
          end
        end
      end
      ST_WR: begin
        if (ab[s_ff.ch]) begin
          n.st  = ST_IDLE;
          n.mwr = 1'b0;
        end else if (mem_ack) begin
          if (d[`MDC_D_WSZ] && !s_ff.hi) begin
            n.hi    = 1'b1;
            n.mwd   = s_ff.data[15:8];
            n.maddr = s_ff.maddr + 16'h0001;
          end else begin
            n.hi  = 1'b0;
            n.mwr = 1'b0;
            c1 = s_ff.cnt[s_ff.ch] + 13'h0001;
            t1 = s_ff.tot[s_ff.ch];
            if (s_ff.first[s_ff.ch] && d[`MDC_D_LENGTH_FROM_DATA_MODE] != `MDC_LENGTH_FROM_DATA_MODE_FIX0 &&
                d[`MDC_D_LENGTH_FROM_DATA_MODE] != `MDC_LENGTH_FROM_DATA_MODE_FIX1)
              t1 = vtotal(d, s_ff.data);
            n.first[s_ff.ch] = 1'b0;
            n.tot[s_ff.ch]   = t1;
            n.cnt[s_ff.ch]   = c1;
            n.src[s_ff.ch]   = step(s_ff.src[s_ff.ch], d[`MDC_D_SINC],
                                    d[`MDC_D_WSZ]);
            n.dst[s_ff.ch]   = step(s_ff.dst[s_ff.ch], d[`MDC_D_DINC],
                                    d[`MDC_D_WSZ]);
            n.st = ST_IDLE;
            if (c1 >= t1) begin
              n.done[s_ff.ch]  = 1'b1;
              n.irq            = d[`MDC_D_IE];
              n.prevp[s_ff.ch] = 1'b1;
              unique case (d[`MDC_D_TRANSFER_MODE_FIELD])
                `MDC_TM_RSINGLE, `MDC_TM_RBLOCK: begin
                  ld  = 1'b1;
                  ldd = d;
                end
                `MDC_TM_SINGLE, `MDC_TM_BLOCK: begin
                  n.armed[s_ff.ch] = 1'b0;
                  n.pend[s_ff.ch]  = 1'b0;
                end
              endcase
            end else if (d[`MDC_D_TRANSFER_MODE_FIELD] == `MDC_TM_BLOCK ||
                         d[`MDC_D_TRANSFER_MODE_FIELD] == `MDC_TM_RBLOCK) begin
              // block keeps going without a trigger
              n.st    = ST_RD;
              n.mrd   = 1'b1;
              n.maddr = n.src[s_ff.ch];
            end
          end
        end
      end
    endcase

    // pointers and count from the descriptor
    if (ld) begin
      n.src[s_ff.ch]   = ldd[`MDC_D_SRC];
      n.dst[s_ff.ch]   = ldd[`MDC_D_DST];
      n.cnt[s_ff.ch]   = '0;
      n.tot[s_ff.ch]   = ldd[`MDC_D_LEN];
      n.first[s_ff.ch] = 1'b1;
    end
    nxt_s = n;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_ff         <= '0;
      s_ff.waitreq <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign avs_readdata    = s_ff.rdata;
  assign avs_waitrequest = s_ff.waitreq;
  assign mem_addr        = s_ff.maddr;
  assign mem_read        = s_ff.mrd;
  assign mem_write       = s_ff.mwr;
  assign mem_wdata       = s_ff.mwd;
  assign done_irq        = s_ff.irq;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic busy_ab;
  logic wr_done;
  logic fetch_end;
  assign busy_ab   = s_ff.st != ST_IDLE && ab[s_ff.ch];
  assign wr_done   = wr_en && avs_address == `MDC_OFS_DONE;
  assign fetch_end = s_ff.st == ST_FETCH && s_ff.bidx == `MDC_DESC_LAST &&
                     mem_ack && !ab[s_ff.ch];

  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence ans_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  abort_disarm_a: assert property ((|ab) |=>
    ((s_ff.armed & $past(ab)) == '0))
    else $error("aborted channel still armed");
  abort_no_irq_a: assert property (busy_ab |=> !done_irq [*2])
    else $error("interrupt after abort");
  abort_flag_a: assert property (busy_ab && !wr_done |=>
    $stable(s_ff.done))
    else $error("done flag changed by abort");
  irq_enable_a: assert property (done_irq |->
    s_ff.done[s_ff.ch] && s_ff.desc[s_ff.ch][`MDC_D_IE])
    else $error("interrupt without enable");
  flag_sticky_a: assert property (!wr_done |=>
    ((s_ff.done & $past(s_ff.done)) == $past(s_ff.done)))
    else $error("done flag lost");
  fetch_arm_a: assert property (fetch_end |=>
    s_ff.armed[$past(s_ff.ch)] && s_ff.st == ST_IDLE)
    else $error("fetch did not arm");
  src_order_a: assert property (fetch_end |=>
    s_ff.src[$past(s_ff.ch)] == s_ff.desc[$past(s_ff.ch)][63:48])
    else $error("source pointer byte order");
  count_cap_a: assert property (s_ff.st == ST_RD |->
    s_ff.tot[s_ff.ch] <= s_ff.desc[s_ff.ch][`MDC_D_LEN])
    else $error("count above cap");
  bus_wait_a: assert property (req_s |=> ans_s)
    else $error("slave answer timing");
endmodule

// File: design/mdc_pkg.sv
// types of the multi-channel transfer engine
// assumes mdc_defines.svh sits beside it
`include "mdc_defines.svh"
package mdc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_RD, ST_WR} mdc_st_t;
  typedef struct packed {
    mdc_st_t                       st;
    logic [2:0]                    ch;
    logic [2:0]                    bidx;
    logic                          hi;
    logic                          defer;
    logic [`MDC_NCH-1:0]           armed;
    logic [`MDC_NCH-1:0]           fetch;
    logic [`MDC_NCH-1:0]           pend;
    logic [`MDC_NCH-1:0]           done;
    logic [`MDC_NCH-1:0]           prevp;
    logic [`MDC_NCH-1:0]           first;
    logic [`MDC_NCH-1:0][63:0]     desc;
    logic [`MDC_NCH-1:0][15:0]     cfg;
    logic [`MDC_NCH-1:0][15:0]     src;
    logic [`MDC_NCH-1:0][15:0]     dst;
    logic [`MDC_NCH-1:0][12:0]     cnt;
    logic [`MDC_NCH-1:0][12:0]     tot;
    logic [15:0]                   data;
    logic                          waitreq;
    logic [31:0]                   rdata;
    logic [15:0]                   maddr;
    logic                          mrd;
    logic                          mwr;
    logic [7:0]                    mwd;
    logic                          irq;
    logic [31:0]                   ps1;
    logic [31:0]                   ps2;
    logic [31:0]                   ps3;
    logic [15:0]                   pp1;
    logic [15:0]                   pp2;
    logic [15:0]                   pp3;
  } mdc_state_t;
endpackage

// File: tb/mdc_mem_model.sv
// byte-wide memory answering the transfer engine's memory port
// assumes requests are held until mem_ack, one clock, bench preloads mem
module mdc_mem_model (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  lat,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_read,
  input  wire logic        mem_write,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata,
  output logic             mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [3:0] wait_ff;
  logic [7:0] last_ff;
  // ack only while a request stands: a dropped request is never answered
  assign mem_ack = (mem_read | mem_write) && (wait_ff >= lat);
  // between answers the lines show the inverse of the last byte, not a copy
  assign mem_rdata = (mem_ack && mem_read) ? mem[mem_addr] : ~last_ff;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wait_ff <= 4'h0;
      last_ff <= 8'h00;
    end else if (mem_ack) begin
      wait_ff <= 4'h0;
      if (mem_read) last_ff <= mem[mem_addr];
      if (mem_write) mem[mem_addr] <= mem_wdata;
    end else if (mem_read | mem_write) begin
      wait_ff <= wait_ff + 4'h1;
    end else begin
      // a dropped request must not leave a head start for the next one
      wait_ff <= 4'h0;
    end
  end
endmodule

// File: tb/tb_multi_channel_dma_abort_irq_descriptor.sv
// testbench of the transfer engine: table of length modes, abort, triggers
// assumes mdc_dma and mdc_mem_model compiled before it
`include "mdc_defines.svh"
module tb_multi_channel_dma_abort_irq_descriptor;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [2:0]  length_from_data_mode;
    logic [12:0] len;
    logic        wsz;
    logic        m8;
    logic [15:0] first;
    int          nb;
  } mdc_row_t;
  logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest, mem_read;
  logic mem_write, mem_ack, cpu_mem_req, done_irq;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, periph_trigger_select;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata, port0_pins, port0_irq_en;
  logic [3:0]  lat;
  int miscompares, n_compared, n_irq;
  // length codes 101 and 110 are reserved and never programmed
  // reserved codes avoided
  mdc_row_t rows [10] = '{
    '{3'h0, 13'h003, 1'b0, 1'b0, 16'h0000, 3},
    '{3'h7, 13'h002, 1'b0, 1'b0, 16'h0000, 2},
    '{3'h1, 13'h00A, 1'b0, 1'b0, 16'h0002, 3},
    '{3'h2, 13'h00A, 1'b0, 1'b0, 16'h0004, 4},
    '{3'h3, 13'h00A, 1'b0, 1'b0, 16'h0002, 4},
    '{3'h4, 13'h00A, 1'b0, 1'b0, 16'h0002, 5},
    '{3'h1, 13'h003, 1'b0, 1'b0, 16'h0009, 3},
    '{3'h1, 13'h00A, 1'b0, 1'b1, 16'h0082, 3},
    '{3'h0, 13'h002, 1'b1, 1'b0, 16'h0000, 4},
    '{3'h2, 13'h00A, 1'b1, 1'b0, 16'hE003, 6}};
  mdc_dma u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mem_addr(mem_addr), .mem_read(mem_read), .mem_write(mem_write),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .cpu_mem_req(cpu_mem_req), .periph_trigger_select(periph_trigger_select),
    .port0_pins(port0_pins), .port0_irq_en(port0_irq_en),
    .port1_pins(8'h00), .port1_irq_en(8'h00), .done_irq(done_irq));
  mdc_mem_model u_mem (.core_clk(core_clk), .sys_rst(sys_rst), .lat(lat),
    .mem_addr(mem_addr), .mem_read(mem_read), .mem_write(mem_write),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (done_irq === 1'b1) n_irq <= n_irq + 1;
  end
  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until the rising edge that sees waitrequest low; data taken
  // there too, then released at once by non-blocking assignment
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    chk("bus answer", 32'h0, {31'h0, avs_waitrequest});
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [5:0] a,
                        input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic poll(input logic [5:0] a, input logic [31:0] m, e);
    logic [31:0] q;
    int k;
    k = 0;
    do begin
      bus(1'b0, a, 32'h0, q);
      k++;
    end while ((q & m) !== e && k < 200);
  endtask
  // descriptor stored big-endian: most significant byte at lowest offset
  task automatic put_desc(input logic [15:0] b, input logic [63:0] d);
    for (int i = 0; i < 8; i++) u_mem.mem[b + i] = d[63 - 8 * i -: 8];
  endtask
  function automatic logic [63:0] dsc(input logic [15:0] s, t,
    input logic [2:0] v, input logic [12:0] n, input logic w,
    input logic [4:0] tr, input logic ie, m8);
    return {s, t, v, n, w, `MDC_TM_BLOCK, tr, `MDC_INC_ONE, `MDC_INC_ONE,
            ie, m8, `MDC_PRIO_HIGH};
  endfunction
  task automatic run_row(input mdc_row_t r, input logic ie);
    int n0;
    for (int i = 0; i < 16; i++) begin
      u_mem.mem[16'h0200 + i] = 8'h40 + i;
      u_mem.mem[16'h0300 + i] = 8'hEE;
    end
    u_mem.mem[16'h0200] = r.first[7:0];
    u_mem.mem[16'h0201] = r.first[15:8];
    put_desc(16'h0100, dsc(16'h0200, 16'h0300, r.length_from_data_mode, r.len, r.wsz,
                           `MDC_TRIGGER_SELECT_NONE, ie, r.m8));
    wr(`MDC_OFS_CFG0, 32'h100);
    wr(`MDC_OFS_ARM, 32'h1);
    poll(`MDC_OFS_ARM, 32'h1, 32'h1);
    n0 = n_irq;
    wr(`MDC_OFS_REQ, 32'h1);
    poll(`MDC_OFS_DONE, 32'h1, 32'h1);
    wr(`MDC_OFS_DONE, 32'h1F);
    rd_chk("done flag held", `MDC_OFS_DONE, 32'h1);
    chk("irq count", {31'h0, ie}, n_irq - n0);
    rd_chk("arm after block", `MDC_OFS_ARM, 32'h0);
    for (int i = 0; i < r.nb; i++)
      chk("copied byte", u_mem.mem[16'h0200 + i],
          u_mem.mem[16'h0300 + i]);
    chk("byte past end", 8'hEE, u_mem.mem[16'h0300 + r.nb]);
    wr(`MDC_OFS_DONE, 32'h0);
    rd_chk("done cleared", `MDC_OFS_DONE, 32'h0);
  endtask
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int n0;
    sys_rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    cpu_mem_req = 1'b1;
    periph_trigger_select = 32'h0;
    port0_pins = 8'h00;
    port0_irq_en = 8'h04;
    lat = 4'h0;
    repeat (16) @(posedge core_clk);
    chk("wait in reset", 32'h1, {31'h0, avs_waitrequest});
    sys_rst <= 1'b0;
    rd_chk("arm reset", `MDC_OFS_ARM, 32'h0);
    rd_chk("done reset", `MDC_OFS_DONE, 32'h0);
    rd_chk("req reads", `MDC_OFS_REQ, 32'h0);
    wr(6'h3C, 32'hFFFFFFFF);
    rd_chk("unmapped", 6'h3C, 32'h0);
    foreach (rows[r]) run_row(rows[r], 1'b1);
    run_row(rows[0], 1'b0);
    // abort: ch0 mid-transfer on slow memory, ch1 armed and idle
    lat <= 4'h4;
    put_desc(16'h0100, dsc(16'h0200, 16'h0300, 3'h0, 13'h028, 1'b0,
                           `MDC_TRIGGER_SELECT_NONE, 1'b1, 1'b0));
    put_desc(16'h0110, dsc(16'h0200, 16'h0340, 3'h0, 13'h005, 1'b0,
                           `MDC_TRIGGER_SELECT_NONE, 1'b1, 1'b0));
    wr(`MDC_OFS_CFG0 + `MDC_CFG_STRIDE, 32'h110);
    wr(`MDC_OFS_ARM, 32'h3);
    poll(`MDC_OFS_ARM, 32'h3, 32'h3);
    n0 = n_irq;
    wr(`MDC_OFS_REQ, 32'h1);
    repeat (30) @(posedge core_clk);
    wr(`MDC_OFS_ARM, 32'h81);
    rd_chk("arm after abort", `MDC_OFS_ARM, 32'h2);
    repeat (40) @(posedge core_clk);
    chk("memory idle", 32'h0, {30'h0, mem_read, mem_write});
    wr(`MDC_OFS_ARM, 32'h82);
    rd_chk("arm all off", `MDC_OFS_ARM, 32'h0);
    rd_chk("done untouched", `MDC_OFS_DONE, 32'h0);
    chk("abort irq", 32'h0, n_irq - n0);
    // triggers: soft, chained, peripheral 5, port 0 pin 2
    lat <= 4'h0;
    put_desc(16'h0120, dsc(16'h0200, 16'h0320, 3'h0, 13'h001, 1'b0,
                           5'h05, 1'b1, 1'b0));
    put_desc(16'h0130, dsc(16'h0200, 16'h0330, 3'h0, 13'h001, 1'b0,
                           `MDC_TRIGGER_SELECT_PORT0, 1'b1, 1'b0));
    put_desc(16'h0110, dsc(16'h0200, 16'h0310, 3'h0, 13'h001, 1'b0,
                           `MDC_TRIGGER_SELECT_PREV, 1'b1, 1'b0));
    for (int c = 0; c < 4; c++)
      wr(`MDC_OFS_CFG0 + 6'(4 * c), 32'h100 + 16 * c);
    wr(`MDC_OFS_ARM, 32'hF);
    poll(`MDC_OFS_ARM, 32'hF, 32'hF);
    periph_trigger_select <= 32'hFFFFFFDF;
    port0_pins <= 8'h02;
    repeat (20) @(posedge core_clk);
    periph_trigger_select <= 32'h0;
    rd_chk("no trigger", `MDC_OFS_DONE, 32'h0);
    port0_pins <= 8'h06;
    poll(`MDC_OFS_DONE, 32'h8, 32'h8);
    rd_chk("port trigger", `MDC_OFS_DONE, 32'h8);
    periph_trigger_select <= 32'h20;
    poll(`MDC_OFS_DONE, 32'h4, 32'h4);
    periph_trigger_select <= 32'h0;
    rd_chk("periph trigger", `MDC_OFS_DONE, 32'hC);
    wr(`MDC_OFS_REQ, 32'h1);
    poll(`MDC_OFS_DONE, 32'h3, 32'h3);
    rd_chk("chained", `MDC_OFS_DONE, 32'hF);
    test_done();
  end
  // a hang of the engine or the bus ends the run here
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    test_done();
  end
endmodule
